// File: hdl/eeprom_read_pkg.sv
// Constants and types for the serial EEPROM read control block
package eeprom_read_pkg;
    localparam int ADDR_W = 14;
    localparam int MEM_DEPTH = 16384;
    localparam int HI_W = ADDR_W - 8;
    localparam logic [3:0] DEV_CLASS = 4'hA;
    localparam logic [7:0] SLEEP_TOGGLE_CMD = 8'hF8;
    localparam logic [7:0] SLEEP_VERIFY_CMD = 8'hF9;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    localparam logic [3:0] BIT_RST = 4'h0;
    localparam logic [1:0] FIFO_FULL = 2'h2;
    localparam logic [1:0] FIFO_EMPTY = 2'h0;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [1:0] SYNC_RST = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RXACK = 3'b011,
        ST_TX = 3'b010,
        ST_TXACK = 3'b110,
        ST_SKIP = 3'b100
    } link_state_t;

    typedef enum logic [1:0] {
        PH_DEV = 2'b00,
        PH_HI = 2'b01,
        PH_LO = 2'b11,
        PH_DATA = 2'b10
    } phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fetch_t;
endpackage : eeprom_read_pkg

// File: hdl/serial_eeprom_read_control.sv
// Two-wire EEPROM slave: addressing, read forms, sleep command answers
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_read_control
    import eeprom_read_pkg::*;
(
    // System side
    input wire logic clock,
    input wire logic rst,
    // Two-wire link, data as open drain
    input wire logic linkClock,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Address straps
    input wire logic [2:0] chipSelectStraps,
    // Status
    output logic sleepActive
);

    function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a);
        nextAddr = a + 14'h0001;
    endfunction : nextAddr

    // Link domain: data bit sampled on the link clock rise
    logic linkBit_q;

    always_ff @(posedge linkClock) begin
        linkBit_q <= sdaIn;
    end

    // Synchronisers for pins
    logic [1:0] sclSync_q;
    logic [1:0] sdaSync_q;
    logic [2:0] strapMeta_q;
    logic [2:0] strap_q;
    logic sclPrev_q;
    logic sdaPrev_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            sclSync_q <= SYNC_RST;
            sdaSync_q <= SYNC_RST;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], linkClock};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            strapMeta_q <= 3'h0;
            strap_q <= 3'h0;
        end else begin
            strapMeta_q <= chipSelectStraps;
            strap_q <= strapMeta_q;
        end
    end

    logic sclRise;
    logic sclFall;
    logic sclHigh;
    logic startEvt;
    logic stopEvt;

    assign sclRise = sclSync_q[1] & ~sclPrev_q;
    assign sclFall = ~sclSync_q[1] & sclPrev_q;
    assign sclHigh = sclSync_q[1] & sclPrev_q;
    assign startEvt = sclHigh & sdaPrev_q & ~sdaSync_q[1];
    assign stopEvt = sclHigh & ~sdaPrev_q & sdaSync_q[1];

    // Control state
    link_state_t state_q;
    phase_t phase_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] txShift_q;
    logic readDir_q;
    logic cmdSeen_q;
    logic masterAck_q;
    logic [HI_W-1:0] addrHi_q;
    logic [ADDR_W-1:0] addrCnt_q;
    logic sdaOe_q;
    logic sdaOut_q;
    logic flushReq_q;
    logic enterPend_q;
    logic exitPend_q;
    logic sleep_q;

    // Storage and prefetch buffer
    logic [7:0] mem [MEM_DEPTH];
    fetch_t fifo_q [2];
    logic wrIdx_q;
    logic rdIdx_q;
    logic [1:0] fill_q;
    logic [ADDR_W-1:0] fetchPtr_q;

    logic fetchValid;
    logic fetchReady;
    logic headValid;
    logic popReq;
    logic push;
    logic pop;
    fetch_t head;

    logic byteDone;
    logic addrMatch;
    logic sleepCmd;
    logic ackNow;
    logic memWe;
    logic loadTx;

    assign addrMatch = (shift_q[7:4] == DEV_CLASS) && (shift_q[3:1] == strap_q);
    assign sleepCmd = (shift_q == SLEEP_TOGGLE_CMD) || (shift_q == SLEEP_VERIFY_CMD);
    assign byteDone = (state_q == ST_RX) && sclFall && (bitCnt_q == BIT_LAST);

    always_comb begin
        ackNow = 1'b1;
        if (phase_q == PH_DEV) begin
            ackNow = (addrMatch || sleepCmd) && !sleep_q;
        end
    end

    assign memWe = byteDone && (phase_q == PH_DATA);

    assign loadTx = sclFall && (bitCnt_q == BIT_ACK) &&
                    (((state_q == ST_RXACK) && readDir_q && !cmdSeen_q && (phase_q == PH_DEV)) ||
                     ((state_q == ST_TXACK) && masterAck_q));

    assign fetchValid = 1'b1;
    assign fetchReady = (fill_q != FIFO_FULL);
    assign headValid = (fill_q != FIFO_EMPTY);
    assign popReq = loadTx;
    assign push = fetchValid && fetchReady && !flushReq_q;
    assign pop = popReq && headValid && !flushReq_q;
    assign head = fifo_q[rdIdx_q];

    always_ff @(posedge clock) begin
        if (memWe) begin
            mem[addrCnt_q] <= shift_q;
        end
    end

    // Two-entry prefetch buffer, refilled from the counter on flush
    always_ff @(posedge clock) begin
        if (rst) begin
            wrIdx_q <= 1'b0;
            rdIdx_q <= 1'b0;
            fill_q <= FIFO_EMPTY;
            fetchPtr_q <= ADDR_RST;
        end else if (flushReq_q) begin
            wrIdx_q <= 1'b0;
            rdIdx_q <= 1'b0;
            fill_q <= FIFO_EMPTY;
            fetchPtr_q <= addrCnt_q;
        end else begin
            if (push) begin
                fifo_q[wrIdx_q] <= '{addr: fetchPtr_q, data: mem[fetchPtr_q]};
                wrIdx_q <= ~wrIdx_q;
                fetchPtr_q <= nextAddr(fetchPtr_q);
            end
            if (pop) begin
                rdIdx_q <= ~rdIdx_q;
            end
            fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Byte level link state machine
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            phase_q <= PH_DEV;
            bitCnt_q <= BIT_RST;
            shift_q <= 8'h00;
            txShift_q <= 8'h00;
            readDir_q <= 1'b0;
            cmdSeen_q <= 1'b0;
            masterAck_q <= 1'b0;
            addrHi_q <= '0;
            addrCnt_q <= ADDR_RST;
            sdaOe_q <= 1'b0;
            flushReq_q <= 1'b0;
            enterPend_q <= 1'b0;
            exitPend_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            flushReq_q <= 1'b0;
            if (startEvt) begin
                state_q <= ST_RX;
                phase_q <= PH_DEV;
                bitCnt_q <= BIT_RST;
                sdaOe_q <= 1'b0;
                flushReq_q <= 1'b1;
            end else if (stopEvt) begin
                state_q <= ST_IDLE;
                sdaOe_q <= 1'b0;
                flushReq_q <= 1'b1;
                if (exitPend_q) begin
                    sleep_q <= 1'b0;
                end else if (enterPend_q) begin
                    sleep_q <= 1'b1;
                end
                exitPend_q <= 1'b0;
                enterPend_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_RX: begin
                        if (sclRise) begin
                            shift_q <= {shift_q[6:0], linkBit_q};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end else if (byteDone) begin
                            if (ackNow) begin
                                sdaOe_q <= 1'b1;
                                state_q <= ST_RXACK;
                            end else begin
                                state_q <= ST_SKIP;
                            end
                            case (phase_q)
                                PH_DEV: begin
                                    readDir_q <= shift_q[0];
                                    cmdSeen_q <= sleepCmd;
                                    if (shift_q == SLEEP_TOGGLE_CMD) begin
                                        if (sleep_q) begin
                                            exitPend_q <= 1'b1;
                                        end else begin
                                            enterPend_q <= 1'b1;
                                        end
                                    end
                                end
                                PH_HI: begin
                                    addrHi_q <= shift_q[HI_W-1:0];
                                end
                                PH_LO: begin
                                    addrCnt_q <= {addrHi_q, shift_q};
                                    flushReq_q <= 1'b1;
                                end
                                default: begin
                                    addrCnt_q <= nextAddr(addrCnt_q);
                                    flushReq_q <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_RXACK: begin
                        if (sclRise) begin
                            bitCnt_q <= BIT_ACK;
                        end else if (sclFall && (bitCnt_q == BIT_ACK)) begin
                            bitCnt_q <= BIT_RST;
                            if (loadTx) begin
                                state_q <= ST_TX;
                                txShift_q <= headValid ? head.data : IDLE_BYTE;
                                sdaOe_q <= headValid ? ~head.data[7] : 1'b0;
                                if (headValid) begin
                                    addrCnt_q <= nextAddr(head.addr);
                                end
                            end else if (cmdSeen_q || (phase_q == PH_DEV && readDir_q)) begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_SKIP;
                            end else begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_RX;
                                case (phase_q)
                                    PH_DEV: phase_q <= PH_HI;
                                    PH_HI: phase_q <= PH_LO;
                                    default: phase_q <= PH_DATA;
                                endcase
                            end
                        end
                    end
                    ST_TX: begin
                        if (sclRise) begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end else if (sclFall) begin
                            if (bitCnt_q == BIT_LAST) begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_TXACK;
                            end else begin
                                txShift_q <= {txShift_q[6:0], 1'b1};
                                sdaOe_q <= ~txShift_q[6];
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (sclRise) begin
                            bitCnt_q <= BIT_ACK;
                            masterAck_q <= ~linkBit_q;
                        end else if (sclFall && (bitCnt_q == BIT_ACK)) begin
                            bitCnt_q <= BIT_RST;
                            if (loadTx) begin
                                state_q <= ST_TX;
                                txShift_q <= headValid ? head.data : IDLE_BYTE;
                                sdaOe_q <= headValid ? ~head.data[7] : 1'b0;
                                if (headValid) begin
                                    addrCnt_q <= nextAddr(head.addr);
                                end
                            end else begin
                                state_q <= ST_SKIP;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sdaOut_q <= 1'b0;
        end else begin
            sdaOut_q <= 1'b0;
        end
    end

    assign sdaOe = sdaOe_q;
    assign sdaOut = sdaOut_q;
    assign sleepActive = sleep_q;

endmodule : serial_eeprom_read_control
`default_nettype wire

// File: sim/link_master_model.sv
// Two-wire bus master model that drives the serial clock
`timescale 1ns/1ns
`default_nettype none
module link_master_model (
    // Link
    output logic scl,
    output logic sdaPull,
    input wire logic sda
);
    logic lclk;

    // Link clock, 15 ns, free of the system clock phase
    initial begin
        lclk = 1'b0;
        scl = 1'b1;
        sdaPull = 1'b0;
        #3;
        forever begin
            #7 lclk = 1'b1;
            #8 lclk = 1'b0;
        end
    end

    task automatic half();
        repeat (4) @(posedge lclk);
    endtask : half

    task automatic bitx(input logic b, output logic r);
        half();
        sdaPull = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        half();
        scl = 1'b0;
    endtask : bitx

    task automatic start();
        half();
        sdaPull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaPull = 1'b1;
        half();
        scl = 1'b0;
    endtask : start

    task automatic stop();
        half();
        sdaPull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sdaPull = 1'b0;
        half();
    endtask : stop

    task automatic byteOut(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(v[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask : byteOut

    // ack asks for more, nack ends
    task automatic byteIn(input logic ackIt, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
        bitx(~ackIt, r);
    endtask : byteIn
endmodule : link_master_model
`default_nettype wire

// File: sim/serial_eeprom_read_control_assertions.sv
// Checker for the link pins of the EEPROM read control block
`timescale 1ns/1ns
`default_nettype none
module eeprom_link_checker (
    // System side
    input wire logic clock,
    input wire logic rst,
    // Link
    input wire logic linkClock,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Straps and status
    input wire logic [2:0] chipSelectStraps,
    input wire logic sleepActive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_reset_quiet: assert property ($fell(rst) |-> !sdaOe && !sleepActive)
        else $error("link driven or asleep after reset");
    chk_open_drain: assert property (sdaOut == 1'b0)
        else $error("data output value not low");
    chk_drive_scl_low: assert property ($changed(sdaOe) |-> !linkClock && !$past(linkClock))
        else $error("data drive changed near clock high");
    chk_sleep_at_stop: assert property ($changed(sleepActive) |-> linkClock && sdaIn)
        else $error("sleep state changed outside a stop");
    chk_asleep_silent: assert property (sleepActive |-> !$rose(sdaOe))
        else $error("device drove the link while asleep");
    chk_bit_hold: assert property ($rose(sdaOe) |=> sdaOe [*8])
        else $error("driven bit too short");
    chk_release_hold: assert property ($fell(sdaOe) |=> !sdaOe [*8])
        else $error("released line taken again too soon");
    chk_quiet_start: assert property ($fell(sdaIn) && linkClock |-> !sdaOe [*4])
        else $error("device drove the link at a start");
endmodule : eeprom_link_checker
`default_nettype wire

// File: sim/serial_eeprom_read_control_test.sv
// Testbench for the EEPROM read control block
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_read_control_test;
    import eeprom_read_pkg::*;
    logic clock, rst, scl, sdaPull, sdaOut, sdaOe, sleepActive, ack;
    wire logic sdaIn;
    logic [2:0] straps;
    logic [7:0] dev, got;
    int err_total, n_compared, cnt;
    int mem [int];

    // Pull-up wire
    assign sdaIn = ~(sdaOe | sdaPull);

    serial_eeprom_read_control u_dut (.clock(clock), .rst(rst), .linkClock(scl), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectStraps(straps), .sleepActive(sleepActive));
    link_master_model u_master (.scl(scl), .sdaPull(sdaPull), .sda(sdaIn));

    always #5 clock = ~clock;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic setAddr(input int a);
        u_master.start();
        u_master.byteOut(dev, ack);
        check({7'h0, ack}, 8'h01);
        u_master.byteOut({2'b00, 6'(a >> 8)}, ack);
        check({7'h0, ack}, 8'h01);
        u_master.byteOut(8'(a), ack);
        check({7'h0, ack}, 8'h01);
        cnt = a;
    endtask : setAddr

    task automatic readBytes(input int n);
        u_master.start();
        u_master.byteOut(dev | 8'h01, ack);
        check({7'h0, ack}, 8'h01);
        for (int k = 0; k < n; k++) begin
            u_master.byteIn(k < n - 1, got);
            check(got, 8'(mem[cnt]));
            cnt = (cnt + 1) % MEM_DEPTH;
        end
        u_master.stop();
    endtask : readBytes

    task automatic probe(input logic [7:0] b, input logic expAck);
        u_master.start();
        u_master.byteOut(b, ack);
        check({7'h0, ack}, {7'h0, expAck});
        u_master.stop();
    endtask : probe

    task automatic waitSleep(input logic exp);
        for (int i = 0; i < 100 && sleepActive !== exp; i++) @(posedge clock);
        repeat (20) @(posedge clock);
        check({7'h0, sleepActive}, {7'h0, exp});
        if (sleepActive !== exp) report_and_stop();
    endtask : waitSleep

    initial begin
        // Run limit, about 40000 clock cycles
        #400000;
        err_total++;
        $display("wrong value at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        err_total = 0;
        n_compared = 0;
        straps = 3'($urandom(80709));
        dev = {DEV_CLASS, straps, 1'b0};
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        repeat (4) @(posedge clock);
        setAddr(MEM_DEPTH - 2);
        for (int k = 0; k < 4; k++) begin
            mem[cnt] = $urandom & 32'hFF;
            u_master.byteOut(8'(mem[cnt]), ack);
            check({7'h0, ack}, 8'h01);
            cnt = (cnt + 1) % MEM_DEPTH;
        end
        u_master.stop();
        $display("test 1 done");
        setAddr(MEM_DEPTH - 1);
        readBytes(1);
        readBytes(1);
        readBytes(1);
        $display("test 2 done");
        setAddr(MEM_DEPTH - 2);
        readBytes(3);
        $display("test 3 done");
        for (int i = 1; i < 4; i++) probe(dev ^ (8'h01 << i) | 8'h01, 1'b0);
        probe({4'hB, straps, 1'b1}, 1'b0);
        readBytes(1);
        $display("test 4 done");
        probe(SLEEP_VERIFY_CMD, 1'b1);
        waitSleep(1'b0);
        probe(SLEEP_TOGGLE_CMD, 1'b1);
        waitSleep(1'b1);
        probe(SLEEP_VERIFY_CMD, 1'b0);
        waitSleep(1'b1);
        probe(dev | 8'h01, 1'b0);
        probe(SLEEP_TOGGLE_CMD, 1'b0);
        waitSleep(1'b0);
        setAddr(0);
        readBytes(2);
        $display("test 5 done");
        report_and_stop();
    end
endmodule : serial_eeprom_read_control_test

bind serial_eeprom_read_control eeprom_link_checker u_chk (.clock(clock), .rst(rst), .linkClock(linkClock),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectStraps(chipSelectStraps), .sleepActive(sleepActive));
`default_nettype wire
